// [hdl/ets_pkg.sv]
// Purpose: Shared constants for the elevator travel and speed select block
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes: Function codes are the values a terminal may be assigned
package ets_pkg;

  // ****************************************
  // Sizes and fixed settings
  // ****************************************
  localparam int SPEED_W = 16;
  localparam int IDX_W = 4;
  localparam int FN_W = 7;
  localparam int TERM_N = 5;
  localparam int CLK_PERIOD_NS = 50;
  // Speed source cannot be changed: digital inputs or keypad values only
  localparam logic SPEED_SOURCE_SELECT = 1'h0;

  // ****************************************
  // Terminal function codes
  // ****************************************
  localparam logic [6:0] FN_SPEED_BIT1 = 7'h03;
  localparam logic [6:0] FN_SPEED_BIT2 = 7'h04;
  localparam logic [6:0] FN_SPEED_BIT3 = 7'h05;
  localparam logic [6:0] FN_INHIBIT_NO = 7'h08;
  localparam logic [6:0] FN_INHIBIT_NC = 7'h09;
  localparam logic [6:0] FN_NOMINAL = 7'h32;
  localparam logic [6:0] FN_INTER = 7'h33;
  localparam logic [6:0] FN_INTER2 = 7'h34;
  localparam logic [6:0] FN_LEVEL = 7'h35;
  localparam logic [6:0] FN_INSPECT = 7'h36;
  localparam logic [6:0] FN_CONTACTOR = 7'h38;

  // ****************************************
  // Modes and sources
  // ****************************************
  localparam logic [1:0] MODE_MULTI1 = 2'h0;
  localparam logic [1:0] MODE_HIGH_PRI = 2'h1;
  localparam logic [1:0] MODE_LEVEL_PRI = 2'h2;
  localparam logic [1:0] MODE_MULTI2 = 2'h3;
  localparam logic RUN_SRC_KEYPAD = 1'h0;
  localparam logic RUN_SRC_TERMINAL = 1'h1;
  localparam logic STOP_RAMP = 1'h0;
  localparam logic STOP_COAST = 1'h1;

  // ****************************************
  // Stored speed slots
  // ****************************************
  localparam logic [3:0] IDX_MULTI_BASE = 4'h0;
  localparam logic [3:0] IDX_NOMINAL = 4'h8;
  localparam logic [3:0] IDX_INTER1 = 4'h9;
  localparam logic [3:0] IDX_INTER2 = 4'hA;
  localparam logic [3:0] IDX_INTER3 = 4'hB;
  localparam logic [3:0] IDX_RELEVEL = 4'hC;
  localparam logic [3:0] IDX_INSPECT = 4'hD;
  localparam logic [3:0] IDX_LEVEL = 4'hE;
  localparam int SPEED_SLOTS = 16;

  // ****************************************
  // Synchroniser bit positions and reset values
  // ****************************************
  localparam int PIN_UP = 0;
  localparam int PIN_DOWN = 1;
  localparam int PIN_SAFE = 2;
  localparam int PIN_KEY_RUN = 3;
  localparam int PIN_KEY_STOP = 4;
  localparam int PIN_TERM0 = 5;
  localparam int PIN_N = 10;
  localparam logic [9:0] PIN_RST = 10'h000;
  localparam logic [15:0] SPEED_RST = 16'h0000;

  typedef enum logic [2:0] {
    ETS_IDLE = 3'b001,
    ETS_UP = 3'b010,
    ETS_DOWN = 3'b100
  } ets_state_t;

endpackage

// [hdl/ets_speed_mem.sv]
// Purpose: Stored speed reference table with registered read
// Assumes: Single clock, synchronous reset clears all slots
// Notes: Read data appear one clock after the address
`timescale 1ns/10ps
`default_nettype none
module ets_speed_mem
  import ets_pkg::*;
#(
  parameter int W = SPEED_W,
  parameter int DEPTH = SPEED_SLOTS,
  parameter int AW = IDX_W
)(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);

  logic [W-1:0] mem_q [DEPTH];

  if (DEPTH > (1 << AW) || W < 1)
    $error("ets_speed_mem: depth does not fit address width");

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
      o_rd_data <= '0;
    end
    else
    begin
      if (i_wr_en)
        mem_q[i_wr_addr] <= i_wr_data;
      o_rd_data <= mem_q[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// [hdl/ets_travel_select.sv]
// Purpose: Travel start/stop decision and speed reference selection
// Assumes: Terminals and keypad keys are asynchronous pins; config and fault are local
// Notes: Speed reference follows the select inputs with four clocks of latency
`timescale 1ns/10ps
`default_nettype none
module ets_travel_select
  import ets_pkg::*;
#(
  parameter int SPEED_WIDTH = SPEED_W
)(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_up_travel_terminal,
  input wire logic i_down_travel_terminal,
  input wire logic i_safety_disable_terminal,
  input wire logic i_key_run,
  input wire logic i_key_stop,
  input wire logic i_aux_a_terminal,
  input wire logic i_aux_b_terminal,
  input wire logic i_select_bit1_terminal,
  input wire logic i_select_bit2_terminal,
  input wire logic i_select_bit3_terminal,
  input wire logic i_run_command_source,
  input wire logic i_keypad_dir_down,
  input wire logic [1:0] i_speed_selection_mode,
  input wire logic i_stop_method_select,
  input wire logic [6:0] i_aux_a_function,
  input wire logic [6:0] i_aux_b_function,
  input wire logic [6:0] i_bit3_function,
  input wire logic i_fault,
  input wire logic i_fault_coast,
  input wire logic i_speed_wr_en,
  input wire logic [3:0] i_speed_wr_index,
  input wire logic [SPEED_WIDTH-1:0] i_speed_wr_value,
  output logic o_run_permit,
  output logic o_dir_up,
  output logic o_dir_down,
  output logic o_brake_apply,
  output logic o_coast_stop,
  output logic o_ramp_stop,
  output logic [SPEED_WIDTH-1:0] o_speed_ref
);

  if (SPEED_WIDTH < 1 || SPEED_WIDTH > 32)
    $error("ets_travel_select: speed width must be 1 to 32");

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_q;
  logic [PIN_N-1:0] sync2_q;
  logic key_run_prev_q;
  logic level_prev_q;
  logic kp_cmd_q;
  logic zero_q;
  ets_state_t state_q;
  ets_state_t state_d;
  logic [SPEED_WIDTH-1:0] mem_rd;

  assign pin_raw = {i_select_bit3_terminal, i_select_bit2_terminal, i_select_bit1_terminal,
                    i_aux_b_terminal, i_aux_a_terminal, i_key_stop, i_key_run,
                    i_safety_disable_terminal, i_down_travel_terminal,
                    i_up_travel_terminal};

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sync1_q <= PIN_RST;
      sync2_q <= PIN_RST;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Terminal function map
  // ****************************************
  function automatic logic fn_on(input logic [TERM_N*FN_W-1:0] fa,
                                 input logic [TERM_N-1:0] t,
                                 input logic [FN_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < TERM_N; i++)
      hit = hit | (t[i] && fa[i*FN_W +: FN_W] == code);
    return hit;
  endfunction

  wire multi_mode = (i_speed_selection_mode == MODE_MULTI1) ||
                    (i_speed_selection_mode == MODE_MULTI2);
  wire sep_mode = !multi_mode;
  wire [TERM_N-1:0] term = sync2_q[PIN_TERM0 +: TERM_N];
  wire [TERM_N-1:0] all_t = {TERM_N{1'b1}};
  // Preset terminals per mode; the free ones follow the config ports
  wire [6:0] fn_a = multi_mode ? i_aux_a_function : FN_NOMINAL;
  wire [6:0] fn_b = multi_mode ? i_aux_b_function : FN_INSPECT;
  wire [6:0] fn_1 = multi_mode ? FN_SPEED_BIT1 : FN_INTER;
  wire [6:0] fn_2 = multi_mode ? FN_SPEED_BIT2 : FN_LEVEL;
  wire [6:0] fn_3 = multi_mode ? FN_SPEED_BIT3 : i_bit3_function;
  wire [TERM_N*FN_W-1:0] input_function_assign = {fn_3, fn_2, fn_1, fn_b, fn_a};

  // ****************************************
  // Speed selection decode
  // ****************************************
  wire [2:0] mbits = {fn_on(input_function_assign, term, FN_SPEED_BIT3),
                      fn_on(input_function_assign, term, FN_SPEED_BIT2),
                      fn_on(input_function_assign, term, FN_SPEED_BIT1)};
  wire n50 = fn_on(input_function_assign, term, FN_NOMINAL);
  wire n51 = fn_on(input_function_assign, term, FN_INTER);
  wire n52 = fn_on(input_function_assign, term, FN_INTER2);
  wire n53 = fn_on(input_function_assign, term, FN_LEVEL);
  wire n54 = fn_on(input_function_assign, term, FN_INSPECT);
  wire lvl_assigned = fn_on(input_function_assign, all_t, FN_LEVEL);
  wire nom_assigned = fn_on(input_function_assign, all_t, FN_NOMINAL);
  wire any_hi = n50 | n51 | n52;
  wire mode_lvl_pri = i_speed_selection_mode == MODE_LEVEL_PRI;
  wire mode_multi2 = i_speed_selection_mode == MODE_MULTI2;

  // Binary code, bit 1 lowest; slot n holds reference n+1
  wire [3:0] multi_idx = 4'(IDX_MULTI_BASE + {1'b0, mbits});
  wire multi_stop = mode_multi2 && mbits == 3'h0;

  wire [3:0] hi_idx =
    ({n50, n51, n52} == 3'b010) ? IDX_INTER1 :
    ({n50, n51, n52} == 3'b111) ? IDX_INTER2 :
    ({n50, n51, n52} == 3'b011) ? IDX_INTER3 :
    ({n50, n51, n52} == 3'b001) ? IDX_RELEVEL : IDX_NOMINAL;

  // No input: unassigned leveling falls to leveling speed (mode 1),
  // unassigned nominal falls to nominal speed (mode 2)
  wire idle_speed = mode_lvl_pri ? !nom_assigned : (!lvl_assigned || n53);
  wire [3:0] idle_idx = mode_lvl_pri ? IDX_NOMINAL : IDX_LEVEL;
  // Leveling overrides in mode 2; in mode 1 other inputs win
  wire [3:0] sep_idx =
    (mode_lvl_pri && n53) ? IDX_LEVEL :
    any_hi ? hi_idx :
    n54 ? IDX_INSPECT :
    idle_idx;
  wire sep_stop = !(mode_lvl_pri && n53) && !any_hi && !n54 && !idle_speed;

  // Source is fixed, so only stored values or the forced zero of a stop decode can ever reach the output
  wire [3:0] sel_idx = multi_mode ? multi_idx : sep_idx;
  wire sel_zero = multi_mode ? multi_stop : sep_stop;

  ets_speed_mem #(
    .W(SPEED_WIDTH),
    .DEPTH(SPEED_SLOTS),
    .AW(IDX_W)
  ) u_mem (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_wr_en(i_speed_wr_en),
    .i_wr_addr(i_speed_wr_index),
    .i_wr_data(i_speed_wr_value),
    .i_rd_addr(sel_idx),
    .o_rd_data(mem_rd)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      zero_q <= 1'b1;
      o_speed_ref <= SPEED_WIDTH'(SPEED_RST);
    end
    else
    begin
      zero_q <= sel_zero;
      o_speed_ref <= zero_q ? '0 : mem_rd;
    end
  end

  // ****************************************
  // Commands and permissives
  // ****************************************
  wire key_run_rise = sync2_q[PIN_KEY_RUN] && !key_run_prev_q;
  wire src_term = i_run_command_source == RUN_SRC_TERMINAL;
  wire cmd_up = src_term ? sync2_q[PIN_UP] : (kp_cmd_q && !i_keypad_dir_down);
  wire cmd_dn = src_term ? sync2_q[PIN_DOWN] : (kp_cmd_q && i_keypad_dir_down);
  wire safe_ok = sync2_q[PIN_SAFE];
  wire inhibit = fn_on(input_function_assign, term, FN_INHIBIT_NO) ||
                 fn_on(input_function_assign, ~term, FN_INHIBIT_NC);
  wire cont_ok = !fn_on(input_function_assign, all_t, FN_CONTACTOR) ||
                 fn_on(input_function_assign, term, FN_CONTACTOR);
  wire hard_stop = !safe_ok || inhibit;
  // Falling edge, so a run that never used leveling is not cut short
  wire lvl_rel = sep_mode && lvl_assigned && level_prev_q && !n53;
  wire stop_any = hard_stop || i_fault || lvl_rel || multi_stop;
  // Output lags the decode by two clocks; a stale nonzero value must not start
  wire start_ok = (o_speed_ref != '0) && !zero_q && !sel_zero &&
                  safe_ok && !inhibit && cont_ok && !stop_any;
  wire running = state_q != ETS_IDLE;
  wire coast = hard_stop ||
               (i_fault ? (i_fault_coast || i_stop_method_select == STOP_COAST)
                        : i_stop_method_select == STOP_COAST);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      key_run_prev_q <= 1'b0;
      level_prev_q <= 1'b0;
      kp_cmd_q <= 1'b0;
    end
    else
    begin
      key_run_prev_q <= sync2_q[PIN_KEY_RUN];
      level_prev_q <= n53;
      // Stop key and any stop drop the latched keypad command
      if (sync2_q[PIN_KEY_STOP] || stop_any)
        kp_cmd_q <= 1'b0;
      else if (key_run_rise)
        kp_cmd_q <= 1'b1;
    end
  end

  // ****************************************
  // Travel state machine
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ETS_IDLE:
      begin
        // Both directions at once is refused
        if (start_ok && cmd_up && !cmd_dn)
          state_d = ETS_UP;
        else if (start_ok && cmd_dn && !cmd_up)
          state_d = ETS_DOWN;
      end
      ETS_UP:
      begin
        if (stop_any || !cmd_up)
          state_d = ETS_IDLE;
      end
      ETS_DOWN:
      begin
        if (stop_any || !cmd_dn)
          state_d = ETS_IDLE;
      end
      default:
        state_d = ETS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_q <= ETS_IDLE;
      o_run_permit <= 1'b0;
      o_dir_up <= 1'b0;
      o_dir_down <= 1'b0;
      o_brake_apply <= 1'b1;
      o_coast_stop <= 1'b0;
      o_ramp_stop <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      o_run_permit <= state_d != ETS_IDLE;
      o_dir_up <= state_d == ETS_UP;
      o_dir_down <= state_d == ETS_DOWN;
      o_brake_apply <= state_d == ETS_IDLE;
      o_coast_stop <= running && state_d == ETS_IDLE && coast;
      o_ramp_stop <= running && state_d == ETS_IDLE && !coast;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_start_speed_nonzero: assert property (
    $rose(o_run_permit) |-> $past(o_speed_ref) != '0)
    else $error("travel started with zero speed");

  a_start_safety_closed: assert property (
    $rose(o_run_permit) |-> $past(safe_ok))
    else $error("travel started with safety open");

  a_start_no_inhibit: assert property (
    $rose(o_run_permit) |-> !$past(inhibit))
    else $error("travel started while inhibited");

  a_start_contactor: assert property (
    $rose(o_run_permit) |-> $past(cont_ok))
    else $error("travel started with contactor open");

  a_cmd_drop_stops: assert property (
    (o_dir_up && !cmd_up) || (o_dir_down && !cmd_dn) |=> !o_run_permit)
    else $error("run kept after command removed");

  a_level_release: assert property (
    lvl_rel |=> !o_run_permit)
    else $error("run kept after leveling release");

  a_mode3_no_input: assert property (
    multi_stop |=> !o_run_permit ##1 !o_run_permit)
    else $error("mode 3 ran with no speed input");

  a_fault_coast: assert property (
    o_run_permit && i_fault && i_fault_coast |=> o_coast_stop && !o_ramp_stop)
    else $error("fault stop did not coast");

  a_hard_stop_brake: assert property (
    o_run_permit && hard_stop |=> o_brake_apply && o_coast_stop && !o_run_permit)
    else $error("hard stop did not brake at once");

  a_keypad_source: assert property (
    $rose(o_run_permit) && $past(i_run_command_source) == RUN_SRC_KEYPAD |-> $past(kp_cmd_q))
    else $error("keypad source ran without key command");

  a_zero_speed_out: assert property (
    sel_zero |-> ##2 o_speed_ref == '0)
    else $error("stop decode gave nonzero speed");

  a_permit_consistent: assert property (
    o_run_permit == (o_dir_up ^ o_dir_down) && o_brake_apply == !o_run_permit)
    else $error("run permit and direction disagree");

  c_run_up: cover property ($rose(o_dir_up));
  c_run_down: cover property ($rose(o_dir_down));
  c_level_stop: cover property (o_run_permit && lvl_rel ##1 !o_run_permit);
  c_keypad_run: cover property (!src_term && $rose(o_run_permit));

endmodule
`default_nettype wire

// [verification/elevator_travel_speed_select_tb_top.sv]
// Purpose: Self-checking bench for travel start, stop and speed selection
// Assumes: Controller model drives direction and multi-speed pins
// Notes: Slot 7 stays zero so that a start on it must be refused
`timescale 1ns/10ps
`default_nettype none
module elevator_travel_speed_select_tb_top;
  import ets_pkg::*;
  logic i_clk, i_srst, safe, key_run, key_stop, aux_a, aux_b, src, sm, fault, fcoast;
  logic up_r, dn_r, slow, up_p, dn_p, wr_en, kp_dn;
  logic [2:0] bits_r, bits_p;
  logic [1:0] mode;
  logic [6:0] fn_a, fn_b;
  logic [3:0] wr_idx;
  logic [15:0] wr_val, o_speed_ref;
  logic o_run_permit, o_dir_up, o_dir_down, o_brake_apply, o_coast_stop, o_ramp_stop;
  int failures, samples_checked;

  ets_ctrl_model ctrl (.i_clk(i_clk), .i_srst(i_srst), .i_slow(slow), .i_req_up(up_r),
    .i_req_down(dn_r), .i_req_bits(bits_r), .o_up(up_p), .o_down(dn_p), .o_bits(bits_p));

  ets_travel_select dut (.i_clk(i_clk), .i_srst(i_srst), .i_up_travel_terminal(up_p),
    .i_down_travel_terminal(dn_p), .i_safety_disable_terminal(safe), .i_key_run(key_run),
    .i_key_stop(key_stop), .i_aux_a_terminal(aux_a), .i_aux_b_terminal(aux_b),
    .i_select_bit1_terminal(bits_p[0]), .i_select_bit2_terminal(bits_p[1]),
    .i_select_bit3_terminal(bits_p[2]), .i_run_command_source(src),
    .i_keypad_dir_down(kp_dn), .i_speed_selection_mode(mode), .i_stop_method_select(sm),
    .i_aux_a_function(fn_a), .i_aux_b_function(fn_b), .i_bit3_function(FN_INTER2),
    .i_fault(fault), .i_fault_coast(fcoast), .i_speed_wr_en(wr_en),
    .i_speed_wr_index(wr_idx), .i_speed_wr_value(wr_val), .o_run_permit(o_run_permit),
    .o_dir_up(o_dir_up), .o_dir_down(o_dir_down), .o_brake_apply(o_brake_apply),
    .o_coast_stop(o_coast_stop), .o_ramp_stop(o_ramp_stop), .o_speed_ref(o_speed_ref));

  // ****
  // Helpers
  // ****
  // Slot 7 left at zero so a start on it must be refused
  function automatic logic [15:0] spd(input int i);
    return (i == 7) ? 16'h0000 : 16'h1000 + 16'(i);
  endfunction
  function automatic logic [15:0] st();
    return {10'h000, o_run_permit, o_dir_up, o_dir_down, o_brake_apply, o_coast_stop,
      o_ramp_stop};
  endfunction
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic drv(input logic u, input logic d, input logic [2:0] b);
    @(posedge i_clk);
    up_r <= u;
    dn_r <= d;
    bits_r <= b;
  endtask
  task automatic wait_permit(input logic v);
    int k = 0;
    while (o_run_permit !== v && k < 30)
    begin
      cyc(1);
      k++;
    end
    if (k == 30)
    begin
      failures++;
      wrap_up();
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_mode0();
    for (int i = 0; i < 15; i++)
    begin
      @(posedge i_clk);
      wr_en <= 1'b1;
      wr_idx <= 4'(i);
      wr_val <= spd(i);
    end
    @(posedge i_clk);
    wr_en <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      drv(1'b0, 1'b0, 3'(i));
      cyc(8);
      chk(o_speed_ref, spd(i));
    end
    $display("test mode0 done");
  endtask
  task automatic t_run();
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      sm <= k[0];
      slow <= k[0];
      drv(!k[0], k[0], 3'h1);
      wait_permit(1'b1);
      chk(st(), k[0] ? 16'h0028 : 16'h0030);
      drv(1'b0, 1'b0, 3'h1);
      wait_permit(1'b0);
      chk(st(), k[0] ? 16'h0006 : 16'h0005);
      cyc(1);
      chk(st(), 16'h0004);
    end
    @(posedge i_clk);
    sm <= 1'b0;
    slow <= 1'b0;
    drv(1'b0, 1'b0, 3'h7);
    cyc(8);
    drv(1'b1, 1'b0, 3'h7);
    cyc(10);
    chk(st(), 16'h0004);
    drv(1'b0, 1'b0, 3'h1);
    cyc(8);
    $display("test run done");
  endtask
  task automatic t_mode3();
    @(posedge i_clk);
    mode <= MODE_MULTI2;
    drv(1'b0, 1'b0, 3'h0);
    cyc(8);
    chk(o_speed_ref, 16'h0000);
    drv(1'b1, 1'b0, 3'h3);
    wait_permit(1'b1);
    chk(o_speed_ref, spd(3));
    drv(1'b1, 1'b0, 3'h0);
    wait_permit(1'b0);
    chk(st(), 16'h0005);
    drv(1'b0, 1'b0, 3'h1);
    @(posedge i_clk);
    mode <= MODE_MULTI1;
    cyc(8);
    $display("test mode3 done");
  endtask
  task automatic t_sep();
    @(posedge i_clk);
    mode <= MODE_HIGH_PRI;
    drv(1'b0, 1'b0, 3'h0);
    cyc(8);
    chk(o_speed_ref, 16'h0000);
    drv(1'b1, 1'b0, 3'h3);
    wait_permit(1'b1);
    chk(o_speed_ref, spd(9));
    drv(1'b1, 1'b0, 3'h2);
    cyc(8);
    chk(o_speed_ref, spd(14));
    chk(st(), 16'h0030);
    drv(1'b1, 1'b0, 3'h0);
    wait_permit(1'b0);
    chk(st(), 16'h0005);
    drv(1'b0, 1'b0, 3'h0);
    @(posedge i_clk);
    mode <= MODE_LEVEL_PRI;
    drv(1'b1, 1'b0, 3'h1);
    wait_permit(1'b1);
    drv(1'b1, 1'b0, 3'h3);
    cyc(8);
    chk(o_speed_ref, spd(14));
    drv(1'b1, 1'b0, 3'h0);
    wait_permit(1'b0);
    chk(st(), 16'h0005);
    drv(1'b0, 1'b0, 3'h0);
    @(posedge i_clk);
    aux_b <= 1'b1;
    cyc(8);
    chk(o_speed_ref, spd(13));
    @(posedge i_clk);
    aux_b <= 1'b0;
    mode <= MODE_MULTI1;
    drv(1'b0, 1'b0, 3'h1);
    cyc(8);
    $display("test sep done");
  endtask
  task automatic t_guards();
    for (int c = 0; c < 2; c++)
    begin
      @(posedge i_clk);
      fn_a <= c[0] ? FN_INHIBIT_NC : FN_INHIBIT_NO;
      aux_a <= !c[0];
      drv(1'b1, 1'b0, 3'h1);
      cyc(10);
      chk(st(), 16'h0004);
      @(posedge i_clk);
      aux_a <= c[0];
      wait_permit(1'b1);
      @(posedge i_clk);
      aux_a <= !c[0];
      wait_permit(1'b0);
      chk(st(), 16'h0006);
      drv(1'b0, 1'b0, 3'h1);
      @(posedge i_clk);
      fn_a <= 7'h00;
      fault <= 1'b0;
      cyc(6);
      drv(1'b1, 1'b0, 3'h1);
      wait_permit(1'b1);
      @(posedge i_clk);
      fault <= 1'b1;
      fcoast <= c[0];
      wait_permit(1'b0);
      chk(st(), c[0] ? 16'h0006 : 16'h0005);
      drv(1'b0, 1'b0, 3'h1);
      @(posedge i_clk);
      fault <= 1'b0;
      cyc(6);
    end
    @(posedge i_clk);
    safe <= 1'b0;
    fn_b <= FN_CONTACTOR;
    aux_b <= 1'b1;
    drv(1'b1, 1'b0, 3'h1);
    cyc(10);
    chk(st(), 16'h0004);
    @(posedge i_clk);
    safe <= 1'b1;
    aux_b <= 1'b0;
    cyc(10);
    chk(st(), 16'h0004);
    @(posedge i_clk);
    aux_b <= 1'b1;
    wait_permit(1'b1);
    @(posedge i_clk);
    safe <= 1'b0;
    wait_permit(1'b0);
    chk(st(), 16'h0006);
    drv(1'b0, 1'b0, 3'h1);
    @(posedge i_clk);
    safe <= 1'b1;
    cyc(6);
    $display("test guards done");
  endtask
  task automatic t_keypad();
    @(posedge i_clk);
    src <= RUN_SRC_KEYPAD;
    drv(1'b1, 1'b0, 3'h1);
    cyc(10);
    chk(st(), 16'h0004);
    for (int d = 0; d < 2; d++)
    begin
      @(posedge i_clk);
      kp_dn <= d[0];
      key_run <= 1'b1;
      repeat (4) @(posedge i_clk);
      key_run <= 1'b0;
      wait_permit(1'b1);
      chk(st(), d[0] ? 16'h0028 : 16'h0030);
      @(posedge i_clk);
      key_stop <= 1'b1;
      wait_permit(1'b0);
      chk(st(), 16'h0005);
      @(posedge i_clk);
      key_stop <= 1'b0;
    end
    $display("test keypad done");
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial
  begin
    failures = 0;
    samples_checked = 0;
    i_srst = 1'b1;
    {safe, key_run, key_stop, aux_a, aux_b, src, sm, fault, fcoast} = 9'h108;
    {up_r, dn_r, slow, wr_en, kp_dn} = 5'h00;
    bits_r = 3'h0;
    mode = MODE_MULTI1;
    fn_a = 7'h00;
    fn_b = 7'h00;
    wr_idx = 4'h0;
    wr_val = 16'h0000;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    cyc(2);
    chk(st(), 16'h0004);
    chk(o_speed_ref, 16'h0000);
    t_mode0();
    t_run();
    t_mode3();
    t_sep();
    t_guards();
    t_keypad();
    wrap_up();
  end
endmodule
`default_nettype wire

// [verification/ets_ctrl_model.sv]
// Purpose: Elevator controller model driving direction and speed select pins
// Assumes: Requests come from the bench; pins change just after a clock edge
// Notes: Slow mode holds every request back by one more clock
`timescale 1ns/10ps
`default_nettype none
module ets_ctrl_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic i_req_up,
  input wire logic i_req_down,
  input wire logic [2:0] i_req_bits,
  output logic o_up,
  output logic o_down,
  output logic [2:0] o_bits
);
  logic [4:0] req_d;
  logic [4:0] late_q;
  logic [4:0] pins_q;
  assign req_d = {i_req_up, i_req_down, i_req_bits};
  // ****
  // Pin drivers
  // ****
  always_ff @(posedge i_clk)
  begin
    late_q <= req_d;
    if (i_srst)
      pins_q <= 5'h00;
    else
      pins_q <= i_slow ? late_q : req_d;
  end
  assign o_up = pins_q[4];
  assign o_down = pins_q[3];
  assign o_bits = pins_q[2:0];
endmodule
`default_nettype wire
